// *** inc/trm_consts.svh ***
`ifndef TRM_CONSTS_SVH
`define TRM_CONSTS_SVH

// register offsets (byte addresses on the module bus)
`define TRM_OFS_ID_LAST 8'h1e
`define TRM_OFS_REVISION 8'h20
`define TRM_OFS_ROUTING 8'h22
`define TRM_OFS_DAC 8'h24
`define TRM_OFS_STATUS 8'h26

// routing selector field positions
`define TRM_POS_GEN1_ARM 0
`define TRM_POS_GEN2_ARM 2
`define TRM_POS_GEN3_ARM 4
`define TRM_POS_ANALYZER 6
`define TRM_POS_GEN2_PULSE 8
`define TRM_POS_GEN3_PULSE 10
`define TRM_POS_SLOT_ZERO 12
`define TRM_POS_ANALOG_A_EN 13
`define TRM_POS_ANALOG_B_EN 14
`define TRM_ROUTING_MASK 16'h7fff

// reset values
`define TRM_ROUTING_RESET 16'h0000
`define TRM_DAC_RESET 16'h0000

// strobe qualification: cycles the strobe must be seen before acting
`define TRM_STROBE_SETTLE_NS 50
`define TRM_CLK_PERIOD_NS 25
`define TRM_STROBE_SETTLE_CYC \
    ((`TRM_STROBE_SETTLE_NS + `TRM_CLK_PERIOD_NS - 1) / `TRM_CLK_PERIOD_NS)

`endif

// *** inc/trm_pkg.sv ***
`default_nettype none
package trm_pkg;
    typedef enum logic [1:0] {
        TRM_SRC_DIFF_A,
        TRM_SRC_DIFF_B,
        TRM_SRC_SYS_A,
        TRM_SRC_SYS_B
    } trm_arm_src_e;

    typedef enum logic [1:0] {
        TRM_PLS_PULSE_B,
        TRM_PLS_PULSE_C,
        TRM_PLS_ANALOG_A,
        TRM_PLS_ANALOG_B
    } trm_pulse_src_e;

    // digitised trigger inputs
    typedef struct packed {
        logic analog_a;
        logic analog_b;
        logic diff_a;
        logic diff_b;
        logic sys_a;
        logic sys_b;
        logic pulse_b;
        logic pulse_c;
    } trm_inputs_s;

    // routed trigger outputs
    typedef struct packed {
        logic ecl_a;
        logic ecl_b;
        logic gen1_arm;
        logic gen2_arm;
        logic gen3_arm;
        logic analyzer;
        logic gen2_pulse;
        logic gen3_pulse;
        logic slot_zero_primary;
        logic slot_zero_second;
        logic slot_zero_third;
    } trm_outputs_s;

    typedef enum {
        TRM_BUS_IDLE,
        TRM_BUS_SETTLE,
        TRM_BUS_ACK
    } trm_bus_e;
endpackage
`default_nettype wire

// *** design/trm_trigger_routing_mux.sv ***
// What this block does
// - decode id block 00-1f, revision 20, routing 22, dac 24, status 26
// - analyzer output picks diff a, diff b, system a, system b
// - generator one arm output uses its own four-way selector
// - generator two arm output uses an independent four-way selector
// - generator three arm output uses an independent four-way selector
// - generator two pulse output picks pulse b, pulse c, analog a, analog b
// - generator three pulse output uses same encoding, independent selector
// - slot-zero primary output: 0 diff a, 1 diff b
// - each analog input has a connect bit; 1 connects its relay
// - analog connect bits live only in the routing selector register
// - system triggers a and b go fixed to ecl outputs a and b
// - comparator threshold comes from the dac control register value
// - registers exchanged over asynchronous 16-bit module bus
// - reset clears every writable control field to zero
`include "trm_consts.svh"
`default_nettype none
module trm_trigger_routing_mux
    import trm_pkg::*;
#(
    parameter logic [15:0] ID_WORD0 = 16'h1234, // arbitrary value
    parameter logic [15:0] REVISION = 16'h0001, // arbitrary value
    parameter logic [15:0] STATUS_WORD = 16'h0000
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    // module bus, strobes active low
    input wire logic cs_n_in,
    input wire logic [7:1] addr_in,
    input wire logic write_n_in,
    input wire logic [1:0] ds_n_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_out,
    output logic dtack_n_out,
    // trigger pins
    input wire trm_inputs_s trig_in,
    output trm_outputs_s trig_out,
    output logic analog_in_a_connect_out,
    output logic analog_in_b_connect_out,
    output logic [15:0] threshold_dac_out
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
logic [2:0] bus_s1_q, bus_s2_q;
logic [2:0] bus_s1_d, bus_s2_d;
trm_inputs_s trig_s1_q, trig_s2_q;
trm_inputs_s trig_s1_d, trig_s2_d;
// address, lanes and data cross beside the strobes, so all of them
// belong to the same access when the settle count runs out
logic [24:0] word_s1_q, word_s2_q;
logic [24:0] word_s1_d, word_s2_d;
logic [7:1] addr_sync;
logic [1:0] lanes_n_sync;
logic [15:0] wdata_sync;

always_comb begin
    bus_s1_d = {cs_n_in, write_n_in, &ds_n_in};
    bus_s2_d = bus_s1_q;
    trig_s1_d = trig_in;
    trig_s2_d = trig_s1_q;
    word_s1_d = {addr_in, ds_n_in, data_in};
    word_s2_d = word_s1_q;
end

always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        bus_s1_q <= 3'h7;
        bus_s2_q <= 3'h7;
        trig_s1_q <= '0;
        trig_s2_q <= '0;
        word_s1_q <= {7'h00, 2'h3, 16'h0000};
        word_s2_q <= {7'h00, 2'h3, 16'h0000};
    end else begin
        bus_s1_q <= bus_s1_d;
        bus_s2_q <= bus_s2_d;
        trig_s1_q <= trig_s1_d;
        trig_s2_q <= trig_s2_d;
        word_s1_q <= word_s1_d;
        word_s2_q <= word_s2_d;
    end
end

assign {addr_sync, lanes_n_sync, wdata_sync} = word_s2_q;

logic cycle_act;
logic cycle_wr;
assign cycle_act = !bus_s2_q[2] && !bus_s2_q[0];
assign cycle_wr = !bus_s2_q[1];

// ----------------------------------------------------------------
// bus handshake
// ----------------------------------------------------------------
// synchronised address, data and lanes are taken after the settle count
localparam int SETTLE = `TRM_STROBE_SETTLE_CYC;
trm_bus_e bus_q, bus_d;
logic [1:0] settle_q, settle_d;
logic [15:0] routing_q, routing_d;
logic [15:0] dac_q, dac_d;
logic [15:0] rdata_q, rdata_d;
logic oe_q, oe_d;
logic dtack_n_q, dtack_n_d;
logic [7:0] offset;
logic [15:0] rd_mux;
logic [15:0] wmask;

assign offset = {addr_sync, 1'b0};
assign wmask = {{8{!lanes_n_sync[1]}}, {8{!lanes_n_sync[0]}}};

always_comb begin
    rd_mux = 16'h0000;
    if (offset == 8'h00) begin
        rd_mux = ID_WORD0;
    end else if (offset <= `TRM_OFS_ID_LAST) begin
        rd_mux = 16'h0000;
    end else if (offset == `TRM_OFS_REVISION) begin
        rd_mux = REVISION;
    end else if (offset == `TRM_OFS_ROUTING) begin
        rd_mux = routing_q & `TRM_ROUTING_MASK;
    end else if (offset == `TRM_OFS_DAC) begin
        rd_mux = dac_q;
    end else if (offset == `TRM_OFS_STATUS) begin
        rd_mux = STATUS_WORD;
    end
end

always_comb begin
    bus_d = bus_q;
    settle_d = settle_q;
    routing_d = routing_q;
    dac_d = dac_q;
    rdata_d = rdata_q;
    oe_d = oe_q;
    dtack_n_d = dtack_n_q;
    case (bus_q)
        TRM_BUS_IDLE: begin
            oe_d = 1'b0;
            dtack_n_d = 1'b1;
            settle_d = 2'h0;
            if (cycle_act) begin
                bus_d = TRM_BUS_SETTLE;
            end
        end
        TRM_BUS_SETTLE: begin
            if (!cycle_act) begin
                bus_d = TRM_BUS_IDLE;
            end else if (settle_q >= 2'(SETTLE - 1)) begin
                bus_d = TRM_BUS_ACK;
                dtack_n_d = 1'b0;
                if (cycle_wr) begin
                    // analog connect only via routing register
                    if (offset == `TRM_OFS_ROUTING) begin
                        routing_d = ((routing_q & ~wmask) | (wdata_sync & wmask))
                            & `TRM_ROUTING_MASK;
                    end
                    if (offset == `TRM_OFS_DAC) begin
                        dac_d = (dac_q & ~wmask) | (wdata_sync & wmask);
                    end
                end else begin
                    rdata_d = rd_mux;
                    oe_d = 1'b1;
                end
            end else begin
                settle_d = settle_q + 2'h1;
            end
        end
        TRM_BUS_ACK: begin
            // hold acknowledge until the carrier drops its strobe
            if (!cycle_act) begin
                bus_d = TRM_BUS_IDLE;
                dtack_n_d = 1'b1;
                oe_d = 1'b0;
            end
        end
        default: begin
            bus_d = TRM_BUS_IDLE;
        end
    endcase
end

always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        bus_q <= TRM_BUS_IDLE;
        settle_q <= 2'h0;
        routing_q <= `TRM_ROUTING_RESET;
        dac_q <= `TRM_DAC_RESET;
        rdata_q <= 16'h0000;
        oe_q <= 1'b0;
        dtack_n_q <= 1'b1;
    end else begin
        bus_q <= bus_d;
        settle_q <= settle_d;
        routing_q <= routing_d;
        dac_q <= dac_d;
        rdata_q <= rdata_d;
        oe_q <= oe_d;
        dtack_n_q <= dtack_n_d;
    end
end

// ----------------------------------------------------------------
// trigger crossbar
// ----------------------------------------------------------------
function automatic logic arm_pick(input logic [1:0] sel, input trm_inputs_s i);
    case (trm_arm_src_e'(sel))
        TRM_SRC_DIFF_A: arm_pick = i.diff_a;
        TRM_SRC_DIFF_B: arm_pick = i.diff_b;
        TRM_SRC_SYS_A: arm_pick = i.sys_a;
        TRM_SRC_SYS_B: arm_pick = i.sys_b;
        default: arm_pick = 1'b0;
    endcase
endfunction

function automatic logic pulse_pick(input logic [1:0] sel, input trm_inputs_s i);
    case (trm_pulse_src_e'(sel))
        TRM_PLS_PULSE_B: pulse_pick = i.pulse_b;
        TRM_PLS_PULSE_C: pulse_pick = i.pulse_c;
        TRM_PLS_ANALOG_A: pulse_pick = i.analog_a;
        TRM_PLS_ANALOG_B: pulse_pick = i.analog_b;
        default: pulse_pick = 1'b0;
    endcase
endfunction

trm_outputs_s route_d, route_q;
always_comb begin
    route_d.gen1_arm = arm_pick(routing_q[`TRM_POS_GEN1_ARM +: 2], trig_s2_q);
    route_d.gen2_arm = arm_pick(routing_q[`TRM_POS_GEN2_ARM +: 2], trig_s2_q);
    route_d.gen3_arm = arm_pick(routing_q[`TRM_POS_GEN3_ARM +: 2], trig_s2_q);
    route_d.analyzer = arm_pick(routing_q[`TRM_POS_ANALYZER +: 2], trig_s2_q);
    route_d.gen2_pulse = pulse_pick(routing_q[`TRM_POS_GEN2_PULSE +: 2], trig_s2_q);
    route_d.gen3_pulse = pulse_pick(routing_q[`TRM_POS_GEN3_PULSE +: 2], trig_s2_q);
    route_d.slot_zero_primary = routing_q[`TRM_POS_SLOT_ZERO] ?
        trig_s2_q.diff_b : trig_s2_q.diff_a;
    route_d.ecl_a = trig_s2_q.sys_a;
    route_d.ecl_b = trig_s2_q.sys_b;
    route_d.slot_zero_second = trig_s2_q.sys_a;
    route_d.slot_zero_third = trig_s2_q.sys_b;
end

// registered outputs cost one clock of latency on every trigger path
always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
        route_q <= '0;
    end else begin
        route_q <= route_d;
    end
end

assign trig_out = route_q;
assign analog_in_a_connect_out = routing_q[`TRM_POS_ANALOG_A_EN];
assign analog_in_b_connect_out = routing_q[`TRM_POS_ANALOG_B_EN];
assign threshold_dac_out = dac_q;
assign data_out = rdata_q;
assign data_oe_out = oe_q;
assign dtack_n_out = dtack_n_q;

endmodule
`default_nettype wire

// *** sim/trm_assertions.sv ***
`default_nettype none
module trm_checker
    import trm_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic cs_n_in,
    input wire logic [7:1] addr_in,
    input wire logic write_n_in,
    input wire logic [1:0] ds_n_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe_out,
    input wire logic dtack_n_out,
    input wire trm_inputs_s trig_in,
    input wire trm_outputs_s trig_out,
    input wire logic analog_in_a_connect_out,
    input wire logic analog_in_b_connect_out,
    input wire logic [15:0] threshold_dac_out
);
    // ----
    // edges since reset, so path checks skip sync fill
    // ----
    logic [2:0] up_q;
    logic [2:0] up_d;
    always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) up_q <= 3'h0;
        else up_q <= up_d;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_req;
        $rose(!cs_n_in && ds_n_in != 2'h3);
    endsequence
    sequence s_rel;
        !dtack_n_out && cs_n_in;
    endsequence
    chk_ack_bound: assert property (s_req |-> ##[3:8] !dtack_n_out)
        else $error("no ack after strobe");
    chk_ack_drop: assert property (s_rel |-> ##[1:5] dtack_n_out)
        else $error("ack held after release");
    chk_oe_read: assert property ($rose(data_oe_out) |->
        write_n_in && !cs_n_in && $fell(dtack_n_out))
        else $error("data driven outside read ack");
    chk_ecl_fixed: assert property (up_q > 3'h3 |->
        trig_out.ecl_a == $past(trig_in.sys_a, 3)
        && trig_out.ecl_b == $past(trig_in.sys_b, 3))
        else $error("ecl path wrong");
    chk_slot_fixed: assert property (up_q > 3'h3 |->
        trig_out.slot_zero_second == $past(trig_in.sys_a, 3)
        && trig_out.slot_zero_third == $past(trig_in.sys_b, 3))
        else $error("slot path wrong");
    chk_route_read: assert property (
        data_oe_out && !dtack_n_out && addr_in == 7'h11 |->
        data_out[15:13] == {1'b0, analog_in_b_connect_out, analog_in_a_connect_out})
        else $error("routing readback wrong");
    chk_dac_read: assert property (
        data_oe_out && !dtack_n_out && addr_in == 7'h12 |->
        data_out == threshold_dac_out)
        else $error("dac readback wrong");
    chk_reset_clear: assert property (up_q == 3'h1 |->
        !analog_in_a_connect_out && !analog_in_b_connect_out
        && threshold_dac_out == 16'h0)
        else $error("not cleared by reset");
endmodule
bind trm_trigger_routing_mux trm_checker u_chk (.clk_in, .resetn_in, .cs_n_in, .addr_in,
    .write_n_in, .ds_n_in, .data_out, .data_oe_out, .dtack_n_out, .trig_in, .trig_out,
    .analog_in_a_connect_out, .analog_in_b_connect_out, .threshold_dac_out);
`default_nettype wire

// *** sim/trm_carrier_model.sv ***
`default_nettype none
module trm_carrier_model (
    input wire logic clk_in,
    input wire logic dtack_n_in,
    input wire logic oe_in,
    input wire logic [15:0] rdata_in,
    output logic cs_n_out,
    output logic [7:1] addr_out,
    output logic write_n_out,
    output logic [1:0] ds_n_out,
    output logic [15:0] data_out,
    output logic fault_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {cs_n_out, write_n_out, ds_n_out} = 4'hf;
        addr_out = 7'h0;
        data_out = 16'h0;
        fault_out = 1'b0;
    end
    task automatic access(input logic wr, input logic [7:0] ofs, input logic [1:0] ln,
        input logic [15:0] d, input int lag, output logic [15:0] q);
        int n;
        @(negedge clk_in);
        addr_out = ofs[7:1];
        write_n_out = !wr;
        data_out = d;
        repeat (lag) @(negedge clk_in);
        cs_n_out = 1'b0;
        ds_n_out = ~ln;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (dtack_n_in !== 1'b0 && n < 40);
        q = oe_in ? rdata_in : 16'hxxxx;
        fault_out = (n >= 40);
        @(negedge clk_in);
        {cs_n_out, ds_n_out} = 3'h7;
        // released bus shows no stale value
        data_out = ~data_out;
        addr_out = ~addr_out;
        n = 0;
        while (dtack_n_in !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        fault_out = fault_out || n >= 40;
        // return off the sampling edge so callers drive pins safely
        @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// *** sim/trigger_routing_mux_test.sv ***
`default_nettype none
module trigger_routing_mux_test
    import trm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] ID0 = 16'h5a3c; // arbitrary value
    localparam logic [15:0] REV = 16'h00a7; // arbitrary value
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cs_n_in, write_n_in, data_oe_out, dtack_n_out, fault;
    logic analog_in_a_connect_out, analog_in_b_connect_out;
    logic [7:1] addr_in;
    logic [1:0] ds_n_in;
    logic [15:0] data_in, data_out, threshold_dac_out;
    trm_inputs_s trig_in = '0;
    trm_outputs_s trig_out;
    int miscompares = 0;
    int num_checks = 0;
    always #12.5 clk_in = ~clk_in;
    trm_trigger_routing_mux #(.ID_WORD0(ID0), .REVISION(REV)) dut (.clk_in, .resetn_in,
        .cs_n_in, .addr_in, .write_n_in, .ds_n_in, .data_in, .data_out, .data_oe_out,
        .dtack_n_out, .trig_in, .trig_out, .analog_in_a_connect_out,
        .analog_in_b_connect_out, .threshold_dac_out);
    trm_carrier_model car (.clk_in, .dtack_n_in(dtack_n_out), .oe_in(data_oe_out),
        .rdata_in(data_out), .cs_n_out(cs_n_in), .addr_out(addr_in),
        .write_n_out(write_n_in), .ds_n_out(ds_n_in), .data_out(data_in), .fault_out(fault));
    task automatic complete_run;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // lag varies so both prompt and slow strobes occur
    task automatic acc(input logic wr, input logic [7:0] ofs, input logic [1:0] ln,
        input logic [15:0] d, output logic [15:0] q);
        car.access(wr, ofs, ln, d, num_checks % 3, q);
        if (fault) begin
            miscompares++;
            complete_run();
        end
    endtask
    // ----
    // map, reset values, lanes
    // ----
    task automatic s_regs;
        logic [15:0] q;
        acc(1'b0, 8'h22, 2'h3, 16'h0, q);
        check(q, 16'h0);
        check({14'h0, analog_in_a_connect_out, analog_in_b_connect_out}, 16'h0);
        acc(1'b0, 8'h00, 2'h3, 16'h0, q);
        check(q, ID0);
        acc(1'b0, 8'h1e, 2'h3, 16'h0, q);
        check(q, 16'h0);
        acc(1'b1, 8'h20, 2'h3, 16'hffff, q);
        acc(1'b0, 8'h20, 2'h3, 16'h0, q);
        check(q, REV);
        acc(1'b0, 8'h26, 2'h3, 16'h0, q);
        check(q, 16'h0);
        acc(1'b1, 8'h28, 2'h3, 16'hffff, q);
        acc(1'b0, 8'h28, 2'h3, 16'h0, q);
        check(q, 16'h0);
        // levels set before differential inputs are used
        acc(1'b1, 8'h24, 2'h3, 16'habcd, q);
        acc(1'b1, 8'h24, 2'h2, 16'h12ff, q);
        acc(1'b0, 8'h24, 2'h3, 16'h0, q);
        check(q, 16'h12cd);
        check(threshold_dac_out, 16'h12cd);
        check({14'h0, analog_in_a_connect_out, analog_in_b_connect_out}, 16'h0);
    endtask
    // ----
    // every selector code, every source
    // ----
    task automatic s_route;
        logic [15:0] w, q;
        trm_outputs_s e;
        for (int c = 0; c < 4; c++) begin
            w = {1'b1, 1'(c / 2), 1'(c % 2), 1'(c % 2), 2'((c + 1) % 4), 2'(c),
                2'((c + 3) % 4), 2'((c + 2) % 4), 2'((c + 1) % 4), 2'(c)};
            acc(1'b1, 8'h22, 2'h3, w, q);
            acc(1'b0, 8'h22, 2'h3, 16'h0, q);
            check(q, w & 16'h7fff);
            check({14'h0, analog_in_a_connect_out, analog_in_b_connect_out},
                16'(c % 2 * 2 + c / 2));
            for (int s = 0; s < 4; s++) begin
                trig_in = trm_inputs_s'(8'(1 << (5 - s)) | 8'(1 << (s < 2 ? 1 - s : 9 - s)));
                repeat (5) @(negedge clk_in);
                e = {s == 2, s == 3, s == c, s == (c + 1) % 4, s == (c + 2) % 4,
                    s == (c + 3) % 4, s == c, s == (c + 1) % 4, s == c % 2, s == 2, s == 3};
                check(16'(trig_out), 16'(e));
            end
        end
    endtask
    // ----
    // reset in mid-run clears what was written
    // ----
    task automatic s_reset;
        logic [15:0] q;
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        check({14'h0, analog_in_a_connect_out, analog_in_b_connect_out}, 16'h0);
        check(threshold_dac_out, 16'h0);
        acc(1'b0, 8'h22, 2'h3, 16'h0, q);
        check(q, 16'h0);
        acc(1'b0, 8'h24, 2'h3, 16'h0, q);
        check(q, 16'h0);
        // system b and analog b still high: only fixed paths follow them
        check(16'(trig_out), 16'h0201);
    endtask
    initial begin
        repeat (12) @(negedge clk_in);
        resetn_in = 1'b1;
        s_regs();
        s_route();
        s_reset();
        complete_run();
    end
endmodule
`default_nettype wire
